// >>> pkg/compare_skip_branch_defines.vh
// Constants shared by the compare, skip and branch unit
`ifndef COMPARE_SKIP_BRANCH_DEFINES_VH
`define COMPARE_SKIP_BRANCH_DEFINES_VH

// ==========================================================
// Status flag bit positions
// ==========================================================
`define FLAG_C 3'h0
`define FLAG_Z 3'h1
`define FLAG_N 3'h2
`define FLAG_V 3'h3
`define FLAG_S 3'h4
`define FLAG_H 3'h5
`define FLAG_T 3'h6
`define FLAG_I 3'h7

// ==========================================================
// Opcode masks and match values (16-bit instruction word)
// ==========================================================
`define MASK_6 16'hfc00
`define MASK_4 16'hf000
`define MASK_BIT_REG 16'hfe08
`define MASK_BIT_IO 16'hff00
`define CODE_SKIP_EQ 16'h1000
`define CODE_CMP 16'h1400
`define CODE_CMPC 16'h0400
`define CODE_CMPI 16'h3000
`define CODE_SKRC 16'hfc00
`define CODE_SKRS 16'hfe00
`define CODE_SKIC 16'h9900
`define CODE_SKIS 16'h9b00
`define CODE_BRFS 16'hf000
`define CODE_BRFC 16'hf400

// ==========================================================
// Operation classes held while executing
// ==========================================================
`define CLASS_NONE 4'h0
`define CLASS_SKIP_EQ 4'h1
`define CLASS_CMP 4'h2
`define CLASS_CMPC 4'h3
`define CLASS_CMPI 4'h4
`define CLASS_SKRC 4'h5
`define CLASS_SKRS 4'h6
`define CLASS_SKIC 4'h7
`define CLASS_SKIS 4'h8
`define CLASS_BRFS 4'h9
`define CLASS_BRFC 4'ha

// ==========================================================
// Cycle counts and operand constants
// ==========================================================
`define CYCLES_ONE 2'h1
`define CYCLES_TWO 2'h2
`define CYCLES_THREE 2'h3
`define HIGH_REG_BIT 1'h1
`define PC_STEP_ONE 16'h0001
`define PC_STEP_TWO 16'h0002
`define PC_STEP_THREE 16'h0003

`endif

// >>> hw/compare_skip_branch_unit.v
// Compare, skip and conditional branch execution unit
`default_nettype none
`include "compare_skip_branch_defines.vh"

// What this block does
// - Equal registers skip next instruction, flags kept
// - Compare ops set Z N V C H, one cycle
// - Register bit clear skips next instruction
// - Register bit set skips next instruction
// - I/O bit clear skips next instruction
// - I/O bit set skips next instruction
// - Flag set branches to pc plus k plus one
// - Flag clear branches to pc plus k plus one
// - Same-or-higher and carry-clear branch on C zero
// - Signed greater-or-equal branches when N xor V zero
// - Signed less-than branches when N xor V one
// - Half-carry clear/set branches on H flag
// - Transfer-bit set branches on T flag one
module compare_skip_branch_unit (
    input wire clock,
    input wire rst,
    input wire instr_valid,
    output wire instr_ready,
    input wire [15:0] instr_word,
    input wire [15:0] instr_pc,
    input wire skip_two_words,
    output reg [4:0] rd_addr,
    output reg [4:0] rr_addr,
    input wire [7:0] rd_value,
    input wire [7:0] rr_value,
    output reg [4:0] io_addr,
    output reg io_read,
    input wire [7:0] io_value,
    input wire [7:0] status_flags,
    output reg [7:0] flags_out,
    output reg flags_write,
    output reg [15:0] pc_next,
    output reg pc_load,
    output reg done
);

    // ==========================================================
    // State encoding
    // ==========================================================
    localparam [1:0] IDLE = 2'h0; // Waiting for an instruction
    localparam [1:0] EXEC = 2'h1; // Operands present, deciding
    localparam [1:0] HOLD = 2'h2; // Burning extra cycles

    reg [1:0] state; // Control state
    reg [3:0] op_class; // Decoded operation of held word
    reg [15:0] word; // Held instruction word
    reg [15:0] pc; // Address of held instruction
    reg [1:0] cnt; // Extra cycles still to wait

    // Combinational results of the execute cycle
    reg [1:0] exec_cycles;
    reg [15:0] exec_pc;
    reg [7:0] exec_flags;
    reg exec_flag_we;
    reg skip_cond;
    reg branch_cond;
    reg flag_bit;
    reg [7:0] cmp_b;
    reg [7:0] test_byte;
    wire [15:0] branch_offset;

    // ==========================================================
    // Functions
    // ==========================================================

    // Decode a word into its operation class
    function [3:0] decode_class;
        input [15:0] w;
        begin
            if ((w & `MASK_6) == `CODE_SKIP_EQ) begin
                decode_class = `CLASS_SKIP_EQ;
            end else if ((w & `MASK_6) == `CODE_CMP) begin
                decode_class = `CLASS_CMP;
            end else if ((w & `MASK_6) == `CODE_CMPC) begin
                decode_class = `CLASS_CMPC;
            end else if ((w & `MASK_4) == `CODE_CMPI) begin
                decode_class = `CLASS_CMPI;
            end else if ((w & `MASK_BIT_REG) == `CODE_SKRC) begin
                decode_class = `CLASS_SKRC;
            end else if ((w & `MASK_BIT_REG) == `CODE_SKRS) begin
                decode_class = `CLASS_SKRS;
            end else if ((w & `MASK_BIT_IO) == `CODE_SKIC) begin
                decode_class = `CLASS_SKIC;
            end else if ((w & `MASK_BIT_IO) == `CODE_SKIS) begin
                decode_class = `CLASS_SKIS;
            end else if ((w & `MASK_6) == `CODE_BRFS) begin
                decode_class = `CLASS_BRFS;
            end else if ((w & `MASK_6) == `CODE_BRFC) begin
                decode_class = `CLASS_BRFC;
            end else begin
                decode_class = `CLASS_NONE;
            end
        end
    endfunction

    // Flags of a minus b minus carry-in; result is discarded
    function [7:0] compare_flags;
        input [7:0] a;
        input [7:0] b;
        input cin;
        input chain;
        input [7:0] old;
        reg [7:0] r;
        reg n;
        reg v;
        begin
            r = a - b - {7'h00, cin};
            n = r[7];
            v = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
            compare_flags = old;
            compare_flags[`FLAG_C] = (~a[7] & b[7]) | (b[7] & r[7])
                | (r[7] & ~a[7]);
            compare_flags[`FLAG_H] = (~a[3] & b[3]) | (b[3] & r[3])
                | (r[3] & ~a[3]);
            compare_flags[`FLAG_N] = n;
            compare_flags[`FLAG_V] = v;
            compare_flags[`FLAG_S] = n ^ v;
            // Chained compare keeps Z only if it was already set
            if (chain) begin
                compare_flags[`FLAG_Z] = (r == 8'h00) & old[`FLAG_Z];
            end else begin
                compare_flags[`FLAG_Z] = (r == 8'h00);
            end
        end
    endfunction

    // ==========================================================
    // Execute-cycle decisions
    // ==========================================================

    // Signed 7-bit offset widened to the counter width
    assign branch_offset = {{9{word[9]}}, word[9:3]};

    // Accept only while nothing is in flight
    assign instr_ready = (state == IDLE);

    // Work out cycles, next pc and flags for the held word
    always @* begin
        exec_cycles = `CYCLES_ONE;
        exec_pc = pc + `PC_STEP_ONE;
        exec_flags = status_flags;
        exec_flag_we = 1'b0;
        skip_cond = 1'b0;
        branch_cond = 1'b0;
        flag_bit = status_flags[word[2:0]];
        // Immediate form uses the constant as second operand
        if (op_class == `CLASS_CMPI) begin
            cmp_b = {word[11:8], word[3:0]};
        end else begin
            cmp_b = rr_value;
        end
        // Byte under bit test: register or I/O location
        if (op_class == `CLASS_SKIC || op_class == `CLASS_SKIS) begin
            test_byte = io_value;
        end else begin
            test_byte = rd_value;
        end
        case (op_class)
            `CLASS_SKIP_EQ: begin
                skip_cond = (rd_value == rr_value);
            end
            `CLASS_CMP, `CLASS_CMPI: begin
                exec_flags = compare_flags(rd_value, cmp_b, 1'b0,
                    1'b0, status_flags);
                exec_flag_we = 1'b1;
            end
            `CLASS_CMPC: begin
                exec_flags = compare_flags(rd_value, cmp_b,
                    status_flags[`FLAG_C], 1'b1,
                    status_flags);
                exec_flag_we = 1'b1;
            end
            `CLASS_SKRC: begin
                skip_cond = ~test_byte[word[2:0]];
            end
            `CLASS_SKRS: begin
                skip_cond = test_byte[word[2:0]];
            end
            `CLASS_SKIC: begin
                skip_cond = ~test_byte[word[2:0]];
            end
            `CLASS_SKIS: begin
                skip_cond = test_byte[word[2:0]];
            end
            `CLASS_BRFS: begin
                // Set-form: equal, carry, lower, minus, half, T
                if (word[2:0] == `FLAG_S) begin
                    // Less-than uses N xor V directly
                    branch_cond = status_flags[`FLAG_N]
                        ^ status_flags[`FLAG_V];
                end else if (word[2:0] == `FLAG_H) begin
                    branch_cond = flag_bit;
                end else if (word[2:0] == `FLAG_T) begin
                    branch_cond = flag_bit;
                end else begin
                    branch_cond = flag_bit;
                end
            end
            `CLASS_BRFC: begin
                // Clear-form: not-equal, plus, carry clear, etc.
                if (word[2:0] == `FLAG_S) begin
                    branch_cond = ~(status_flags[`FLAG_N]
                        ^ status_flags[`FLAG_V]);
                end else if (word[2:0] == `FLAG_C) begin
                    branch_cond = ~flag_bit;
                end else if (word[2:0] == `FLAG_H) begin
                    branch_cond = ~flag_bit;
                end else begin
                    branch_cond = ~flag_bit;
                end
            end
            default: begin
                // Unknown word: one cycle, step to next word
                skip_cond = 1'b0;
            end
        endcase
        // Skip length follows the size of the skipped word
        if (skip_cond) begin
            if (skip_two_words) begin
                exec_cycles = `CYCLES_THREE;
                exec_pc = pc + `PC_STEP_THREE;
            end else begin
                exec_cycles = `CYCLES_TWO;
                exec_pc = pc + `PC_STEP_TWO;
            end
        end
        // Taken branch costs one extra cycle
        if (branch_cond) begin
            exec_cycles = `CYCLES_TWO;
            exec_pc = pc + branch_offset + `PC_STEP_ONE;
        end
    end

    // ==========================================================
    // Sequencer
    // ==========================================================

    // One instruction at a time; done marks its last cycle's end
    always @(posedge clock) begin
        if (rst) begin
            state <= IDLE;
            op_class <= `CLASS_NONE;
            word <= 16'h0000;
            pc <= 16'h0000;
            cnt <= 2'h0;
            rd_addr <= 5'h00;
            rr_addr <= 5'h00;
            io_addr <= 5'h00;
            io_read <= 1'b0;
            flags_out <= 8'h00;
            flags_write <= 1'b0;
            pc_next <= 16'h0000;
            pc_load <= 1'b0;
            done <= 1'b0;
        end else begin
            case (state)
                IDLE: begin
                    // Result pulses last a single cycle
                    done <= 1'b0;
                    pc_load <= 1'b0;
                    flags_write <= 1'b0;
                    if (instr_valid) begin
                        word <= instr_word;
                        pc <= instr_pc;
                        op_class <= decode_class(instr_word);
                        io_addr <= instr_word[7:3];
                        rr_addr <= {instr_word[9], instr_word[3:0]};
                        // Immediate compare reaches upper half only
                        if (decode_class(instr_word) == `CLASS_CMPI) begin
                            rd_addr <= {`HIGH_REG_BIT, instr_word[7:4]};
                        end else begin
                            rd_addr <= instr_word[8:4];
                        end
                        // I/O read is held only through execute
                        io_read <= (decode_class(instr_word) == `CLASS_SKIC)
                            | (decode_class(instr_word) == `CLASS_SKIS);
                        state <= EXEC;
                    end
                end
                EXEC: begin
                    io_read <= 1'b0;
                    pc_next <= exec_pc;
                    // Flags stay put for all but compares
                    if (exec_flag_we) begin
                        flags_out <= exec_flags;
                    end
                    if (exec_cycles == `CYCLES_ONE) begin
                        flags_write <= exec_flag_we;
                        pc_load <= 1'b1;
                        done <= 1'b1;
                        state <= IDLE;
                    end else begin
                        // Extra hold cycles beyond the first hold one
                        cnt <= exec_cycles - `CYCLES_TWO;
                        state <= HOLD;
                    end
                end
                HOLD: begin
                    if (cnt == 2'h0) begin
                        pc_load <= 1'b1;
                        done <= 1'b1;
                        state <= IDLE;
                    end else begin
                        cnt <= cnt - 2'h1;
                    end
                end
                default: begin
                    // Stray code recovers to idle
                    state <= IDLE;
                end
            endcase
        end
    end

endmodule
`default_nettype wire

// >>> sim/compare_skip_branch_unit_sva.sv
// Assertion checker for the compare, skip and branch unit
`default_nettype none
module compare_skip_branch_unit_sva (
    input wire logic clock,
    input wire logic rst,
    input wire logic instr_valid,
    input wire logic instr_ready,
    input wire logic [15:0] instr_word,
    input wire logic [15:0] instr_pc,
    input wire logic io_read,
    input wire logic [7:0] io_value,
    input wire logic [7:0] status_flags,
    input wire logic flags_write,
    input wire logic [15:0] pc_next,
    input wire logic pc_load,
    input wire logic done
);
    timeunit 1ns;
    timeprecision 1ns;
    // ========================================
    // Capture of the instruction in flight
    // ========================================
    logic [15:0] cw;
    logic [15:0] cp;
    logic [7:0] cf;
    // Cycles since take, equal to the cycle count at done
    logic [2:0] cnt;
    logic take, cmp, io, skip, br, sel;
    assign take = instr_valid && instr_ready;
    assign cmp = cw[15:10] == 6'h05 || cw[15:10] == 6'h01 || cw[15:12] == 4'h3;
    assign io = cw[15:10] == 6'h26 && cw[8];
    assign skip = io || cw[15:10] == 6'h04 || (cw[15:10] == 6'h3F && !cw[3]);
    assign br = cw[15:11] == 5'h1E;
    // Signed branch uses N xor V, not the stored sign bit
    assign sel = (cw[2:0] == 3'h4) ? cf[2] ^ cf[3] : cf[cw[2:0]];
    // Captures need no reset: done stays low until a take
    always_ff @(posedge clock) begin
        if (take) begin
            cw <= instr_word;
            cp <= instr_pc;
            cf <= status_flags;
        end
        cnt <= (rst || take) ? 3'h0 : cnt + 3'h1;
    end
    // ========================================
    // Properties
    // ========================================
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    sequence s_exec;
        !instr_ready;
    endsequence
    sequence s_cmp_end;
        done && flags_write && pc_next == cp + 16'h0001;
    endsequence
    AST_CMP_TIME: assert property (
        take ##1 cmp |-> s_exec ##1 s_cmp_end)
        else $error("compare did not end after one cycle");
    AST_FLAGS_CMP_ONLY: assert property (
        flags_write |-> done && cmp)
        else $error("flag write outside a compare");
    AST_DONE_BOUND: assert property (
        take |-> ##[2:4] (done && pc_load))
        else $error("no done within three cycles");
    AST_SKIP_STEP: assert property (
        done && skip |-> cnt != 3'h0 && pc_next == cp + {13'h0000, cnt})
        else $error("skip step differs from cycle count");
    AST_BR_STEP: assert property (
        done && br |-> (cnt == 3'h1 && pc_next == cp + 16'h0001) ||
        (cnt == 3'h2 && pc_next == cp + {{9{cw[9]}}, cw[9:3]} + 16'h0001))
        else $error("branch target or time wrong");
    AST_BR_COND: assert property (
        done && br |-> (cnt == 3'h2) == (sel ^ cw[10]))
        else $error("branch decision wrong");
    AST_IO_SKIP: assert property (
        done && io |-> (cnt > 3'h1) == (io_value[cw[2:0]] == cw[9]))
        else $error("io skip decision wrong");
    AST_IO_READ: assert property (
        take ##1 io |-> io_read ##1 !io_read)
        else $error("io read strobe not one cycle");
endmodule

bind compare_skip_branch_unit compare_skip_branch_unit_sva i_sva (
    .clock, .rst, .instr_valid, .instr_ready, .instr_word, .instr_pc,
    .io_read, .io_value, .status_flags, .flags_write, .pc_next,
    .pc_load, .done
);
`default_nettype wire

// >>> sim/compare_skip_branch_unit_test.sv
// Self-checking testbench for the compare, skip and branch unit
`default_nettype none
module compare_skip_branch_unit_test;
    timeunit 1ns;
    timeprecision 1ns;
    // ========================================
    // Stimulus, register model and results
    // ========================================
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic instr_valid = 1'b0;
    logic skip_two_words = 1'b0;
    logic [15:0] instr_word = 16'h0000;
    logic [15:0] instr_pc = 16'h0000;
    logic [7:0] status_flags = 8'h00;
    // Register file and I/O space, read without delay
    logic [7:0] regs [32];
    logic [7:0] ioregs [32];
    wire logic instr_ready, io_read, flags_write, pc_load, done;
    wire logic [4:0] rd_addr, rr_addr, io_addr;
    wire logic [7:0] flags_out;
    wire logic [15:0] pc_next;
    wire logic [7:0] rd_value = regs[rd_addr];
    wire logic [7:0] rr_value = regs[rr_addr];
    wire logic [7:0] io_value = ioregs[io_addr];
    int failures = 0;
    int checked = 0;
    int cycles = 0;
    compare_skip_branch_unit i_dut (
        .clock, .rst, .instr_valid, .instr_ready, .instr_word, .instr_pc,
        .skip_two_words, .rd_addr, .rr_addr, .rd_value, .rr_value,
        .io_addr, .io_read, .io_value, .status_flags, .flags_out,
        .flags_write, .pc_next, .pc_load, .done
    );
    // 50 ns period
    initial begin
        forever #25 clock = ~clock;
    end
    // ========================================
    // Shared tasks
    // ========================================
    task automatic wrap_up;
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input logic ok, input string msg);
        checked++;
        if (ok !== 1'b1) begin
            failures++;
            $display("MISMATCH %0t %s", $time, msg);
        end
    endtask
    // Hang guard: the run needs under two hundred cycles
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            failures++;
            $display("MISMATCH %0t run did not finish", $time);
            wrap_up();
        end
    end
    // One instruction: offer, withdraw after take, time the done pulse
    task automatic run(input logic [15:0] w, input logic [15:0] pc,
        input logic two, input int n, input logic [15:0] pe,
        input logic [7:0] sf = 8'h00, input logic fw = 1'b0,
        input logic [7:0] fl = 8'h00);
        int c;
        c = 0;
        @(posedge clock);
        instr_valid <= 1'b1;
        instr_word <= w;
        instr_pc <= pc;
        skip_two_words <= two;
        status_flags <= sf;
        @(posedge clock);
        instr_valid <= 1'b0;
        // Sample just after the edge so the pulse has landed
        do begin
            @(posedge clock);
            #1;
            c++;
        end while (done !== 1'b1 && c < 6);
        chk(c == n && pc_load === 1'b1, "cycle count");
        chk(pc_next === pe, "next address");
        chk(flags_write === fw, "flag write");
        if (fw)
            chk(flags_out === fl, "flag values");
    endtask
    // ========================================
    // Scenarios
    // ========================================
    task automatic t_cmp;
        run(16'h1412, 16'h0010, 0, 1, 16'h0011, 8'h00, 1, 8'h15);
        run(16'h1433, 16'h0010, 0, 1, 16'h0011, 8'h00, 1, 8'h02);
        run(16'h0433, 16'h0020, 0, 1, 16'h0021, 8'h40, 1, 8'h40);
        run(16'h0433, 16'h0020, 0, 1, 16'h0021, 8'h42, 1, 8'h42);
        run(16'h0433, 16'h0020, 0, 1, 16'h0021, 8'h01, 1, 8'h35);
        run(16'h3800, 16'h0030, 0, 1, 16'h0031, 8'h00, 1, 8'h0D);
        run(16'h0000, 16'h0040, 0, 1, 16'h0041);
        $display("compare tests done");
    endtask
    // Flags all set in the equal-register skip runs so any flag write would show
    task automatic t_skip;
        run(16'h1011, 16'h0050, 0, 2, 16'h0052, 8'hFF);
        run(16'h1011, 16'h0050, 1, 3, 16'h0053, 8'hFF);
        run(16'h1012, 16'h0050, 0, 1, 16'h0051, 8'hFF);
        run(16'hFC51, 16'h0060, 0, 2, 16'h0062);
        run(16'hFC50, 16'h0060, 0, 1, 16'h0061);
        run(16'hFE50, 16'h0060, 1, 3, 16'h0063);
        run(16'hFE51, 16'h0060, 0, 1, 16'h0061);
        run(16'h991C, 16'h0070, 1, 3, 16'h0073);
        run(16'h9918, 16'h0070, 0, 1, 16'h0071);
        run(16'h9B18, 16'h0070, 0, 2, 16'h0072);
        run(16'h9B1C, 16'h0070, 0, 1, 16'h0071);
        $display("skip tests done");
    endtask
    // Every flag, set and clear, two flag patterns and both offset signs
    task automatic t_branch;
        logic [7:0] f;
        logic [15:0] k;
        logic [3:0] sv;
        logic tk;
        for (int p = 0; p < 2; p++) begin
            for (int s = 0; s < 16; s++) begin
                sv = s[3:0];
                f = p ? 8'hB1 : 8'h4A;
                k = p ? 16'h003F : 16'hFFFD;
                tk = ((sv[2:0] == 3'h4) ? f[2] ^ f[3] : f[sv[2:0]]) ^ sv[3];
                run({5'h1E, sv[3], k[6:0], sv[2:0]}, 16'h0100, 0,
                    tk ? 2 : 1, tk ? 16'h0101 + k : 16'h0101, f);
            end
        end
        $display("branch tests done");
    endtask
    initial begin
        foreach (regs[i]) begin
            regs[i] = 8'h00;
            ioregs[i] = 8'h00;
        end
        regs[1] = 8'h10;
        regs[2] = 8'h20;
        regs[3] = 8'h55;
        regs[5] = 8'hA5;
        regs[16] = 8'h7F;
        ioregs[3] = 8'h0F;
        repeat (5) @(posedge clock);
        rst <= 1'b0;
        #1;
        chk(instr_ready === 1'b1 && done === 1'b0, "reset state");
        t_cmp;
        t_skip;
        t_branch;
        wrap_up;
    end
endmodule
`default_nettype wire
